// ===== verilog/stsp_pkg.sv
// Shared constants and types for the transducer serial port.
package stsp_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_MHZ = 125;
    // Least low time of one byte acknowledge pulse, in ns.
    localparam int ACK_LOW_NS = 200;
    localparam int ACK_LOW_CYC = (ACK_LOW_NS * CLK_MHZ + 999) / 1000;
    // Worst case channel warm-up time, in ns.
    localparam int WARMUP_NS = 1000000;
    localparam int WARMUP_CYC = WARMUP_NS / 1000 * CLK_MHZ;

    // ****************************************************************
    // Frame layout
    // ****************************************************************
    localparam int NUM_CHAN = 3;
    localparam logic [2:0] IDX_FUNC = 3'h0;
    localparam logic [2:0] IDX_CHAN = 3'h1;
    localparam logic [2:0] IDX_DATA = 3'h2;
    localparam logic [2:0] IDX_MAX = 3'h7;

    // ****************************************************************
    // Function codes
    // ****************************************************************
    localparam logic [7:0] FN_WRITE_DATA = 8'h00;
    localparam logic [7:0] FN_WRITE_MASK = 8'h04;
    localparam logic [7:0] FN_WRITE_AUX_MASK = 8'h06;
    localparam logic [7:0] FN_READ_DATA = 8'h80;
    localparam logic [7:0] FN_READ_STATUS = 8'h82;
    localparam logic [7:0] FN_READ_MASK = 8'h84;
    localparam logic [7:0] FN_READ_AUX_STATUS = 8'h85;
    localparam logic [7:0] FN_READ_AUX_MASK = 8'h86;

    // ****************************************************************
    // Status word bit positions and reset values
    // ****************************************************************
    localparam int ST_BIT_TRIG = 1;
    localparam int ST_BIT_OPER = 2;
    localparam int ST_BIT_AUX = 3;
    localparam int ST_BIT_WRITTEN = 4;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // ****************************************************************
    // Core sequencer states
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FRAME = 4'b0010,
        ST_ACK = 4'b0100,
        ST_TRIG = 4'b1000
    } stsp_state_t;

endpackage : stsp_pkg

// ===== verilog/stsp_link_if.sv
// Carrier between the link clock logic and the core logic.
`timescale 1ns/100ps
interface stsp_link_if;
    logic [7:0] rxByte;
    logic byteToggle;
    logic [7:0] txByte;

    modport link (
        output rxByte,
        output byteToggle,
        input txByte
    );
    modport core (
        input rxByte,
        input byteToggle,
        output txByte
    );
endinterface : stsp_link_if

// ===== verilog/stsp_link.sv
// Bit shifter running on the link clock.
`timescale 1ns/100ps
module stsp_link (
    input wire logic linkClk,
    input wire logic reset_n,
    input wire logic frameN,
    input wire logic linkDataIn,
    output logic linkDataOut,
    stsp_link_if.link bus
);

    // Frame scoped part: cleared while the frame is idle.
    typedef struct packed {
        logic [2:0] bitCnt;
        logic [7:0] rxShift;
        logic [7:0] txShift;
    } stsp_bits_t;

    // Persistent part: last byte and its event toggle.
    typedef struct packed {
        logic [7:0] rxByte;
        logic toggle;
    } stsp_word_t;

    stsp_bits_t bits_q;
    stsp_bits_t bits_d;
    stsp_word_t word_q;
    stsp_word_t word_d;
    logic bitsRstN;

    // The link clock stops outside frames, so the idle frame itself
    // clears the bit counter.
    assign bitsRstN = reset_n & ~frameN; // R24

    // Next state of the shifters.
    always_comb begin
        bits_d = bits_q;
        word_d = word_q;
        bits_d.bitCnt = bits_q.bitCnt + 3'h1; // R15 R14
        bits_d.rxShift = {bits_q.rxShift[6:0], linkDataIn}; // R1
        if (bits_q.bitCnt == 3'h0) begin
            bits_d.txShift = {bus.txByte[6:0], 1'b0};
        end else begin
            bits_d.txShift = {bits_q.txShift[6:0], 1'b0};
        end
        if (bits_q.bitCnt == 3'h7) begin
            word_d.rxByte = {bits_q.rxShift[6:0], linkDataIn};
            word_d.toggle = ~word_q.toggle;
        end
    end

    // Bit state register.
    always_ff @(posedge linkClk or negedge bitsRstN) begin
        if (!bitsRstN) begin
            bits_q <= '0;
        end else begin
            bits_q <= bits_d;
        end
    end

    // Byte state register.
    always_ff @(posedge linkClk or negedge reset_n) begin
        if (!reset_n) begin
            word_q <= '0;
        end else begin
            word_q <= word_d;
        end
    end

    // The first bit comes straight from the core's byte, which is held
    // still while the partner waits for the acknowledge.
    assign linkDataOut = (bits_q.bitCnt == 3'h0) ? bus.txByte[7]
                                                 : bits_q.txShift[7];
    assign bus.rxByte = word_q.rxByte;
    assign bus.byteToggle = word_q.toggle;

endmodule : stsp_link

// ===== verilog/stsp_port.sv
// Transducer side serial port with loopback channels.
`timescale 1ns/100ps

// Overview of operation
// R1 - Data sampled and shifted on rising link clock.
// R2 - Input carries address and data; output data only.
// R3 - Frame select level delimits every frame.
// R4 - Acknowledge falls for trigger and each byte.
// R5 - Service request line falls on pending interrupt.
// R6 - Presence line is an active low level.
// R7 - Only read, write and trigger transactions.
// R8 - Trigger acknowledged well within 6 us.
// R9 - Trigger acknowledge removed within 10 us.
// R10 - Commands finished within 100 us.
// R11 - Partner waits 160 us before read frame.
// R12 - Partner spaces triggers by 160 us.
// R13 - Partner waits 15 us after write frame.
// R14 - Link sustains up to 5 Mbps.
// R15 - Eight bits per byte, then byte handshake.
// R16 - Channel 0 read returns six bytes.
// R17 - Frame end recognised within 50 us.
// R18 - Data frame with pacing takes about 75 us.
// R19 - Channel 1 actuator, channel 2 sensor, 16 bit.
// R20 - Trigger copies actuator value into sensor.
// R21 - Channels ready after 1 ms warm-up.
// R22 - Status, mask, aux status, aux mask functions.
// R23 - Aux status interrupts by two paths.
// R24 - Idle frame resets bit and byte counters.
// R25 - Presence line held low permanently.
module stsp_port #(
    parameter int WARMUP_CYCLES = stsp_pkg::WARMUP_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic linkClk,
    input wire logic frameN,
    input wire logic trigN,
    input wire logic linkDataIn,
    output logic linkDataOut,
    output logic ackN,
    output logic serviceReqN,
    output logic presentN,
    input wire logic [2:0][15:0] auxEvent,
    output logic [15:0] actuatorValue,
    output logic [15:0] sensorValue,
    output logic channelReady
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0] frameSync;
        logic [1:0] trigSync;
        logic trigSeen;
        logic [1:0] togSync;
        logic togSeen;
        stsp_pkg::stsp_state_t state;
        logic [7:0] ackCnt;
        logic [2:0] byteIdx;
        logic [7:0] func;
        logic [7:0] chan;
        logic [7:0] txByte;
        logic [15:0] actuator;
        logic [15:0] sensor;
        logic [2:0][15:0] statusEv;
        logic [2:0][15:0] mask;
        logic [2:0][15:0] auxStat;
        logic [2:0][15:0] auxMask;
        logic [19:0] warmCnt;
        logic ready;
        logic ackN;
        logic svcN;
    } stsp_core_t;

    stsp_core_t core_q;
    stsp_core_t core_d;

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Live status word of one channel; channel 0 is the global word.
    function automatic logic [15:0] chanStatus(
        input stsp_core_t s,
        input logic [1:0] c
    );
        logic [15:0] w;
        w = s.statusEv[c];
        w[stsp_pkg::ST_BIT_OPER] = s.ready;
        w[stsp_pkg::ST_BIT_AUX] = |s.auxStat[c]; // R23
        return w;
    endfunction : chanStatus

    // Byte returned at frame position idx for the decoded function.
    function automatic logic [7:0] readByte(
        input stsp_core_t s,
        input logic [2:0] idx
    );
        logic [15:0] word;
        logic [1:0] c;
        logic [7:0] res;
        word = stsp_pkg::WORD_RST;
        res = stsp_pkg::BYTE_RST;
        c = s.chan[1:0];
        if (s.chan < 8'(stsp_pkg::NUM_CHAN)) begin
            case (s.func)
                stsp_pkg::FN_READ_DATA: begin // R19
                    word = (c == 2'h1) ? s.actuator : s.sensor;
                end
                stsp_pkg::FN_READ_STATUS: begin // R22
                    word = chanStatus(s, c);
                end
                stsp_pkg::FN_READ_MASK: begin // R22
                    word = s.mask[c];
                end
                stsp_pkg::FN_READ_AUX_STATUS: begin // R22
                    word = s.auxStat[c];
                end
                stsp_pkg::FN_READ_AUX_MASK: begin // R22
                    word = s.auxMask[c];
                end
                default: begin
                    word = stsp_pkg::WORD_RST;
                end
            endcase
        end
        if (s.func == stsp_pkg::FN_READ_DATA && s.chan == 8'h00) begin
            case (idx) // R16
                3'h2: res = s.actuator[15:8];
                3'h3: res = s.actuator[7:0];
                3'h4: res = s.sensor[15:8];
                3'h5: res = s.sensor[7:0];
                default: res = stsp_pkg::BYTE_RST;
            endcase
        end else if (idx == stsp_pkg::IDX_DATA) begin
            res = word[15:8];
        end else if (idx == stsp_pkg::IDX_DATA + 3'h1) begin
            res = word[7:0];
        end
        return res; // R2
    endfunction : readByte

    // ****************************************************************
    // Link clock logic
    // ****************************************************************
    stsp_link_if linkBus ();

    // Shifter on the partner's clock; bytes cross by toggle handshake.
    stsp_link stsp_link_i (
        .linkClk(linkClk),
        .reset_n(reset_n),
        .frameN(frameN),
        .linkDataIn(linkDataIn),
        .linkDataOut(linkDataOut),
        .bus(linkBus)
    );

    // ****************************************************************
    // Core sequencer
    // ****************************************************************
    logic frameActive;
    logic trigFall;
    logic byteEv;
    logic irq;
    logic [1:0] c;
    logic chanOk;

    // Next state of the whole core.
    always_comb begin
        core_d = core_q;
        // Pins from the other party pass two flip-flops first.
        core_d.frameSync = {core_q.frameSync[0], frameN};
        core_d.trigSync = {core_q.trigSync[0], trigN};
        core_d.trigSeen = core_q.trigSync[1];
        core_d.togSync = {core_q.togSync[0], linkBus.byteToggle};
        core_d.togSeen = core_q.togSync[1];
        frameActive = ~core_q.frameSync[1]; // R3
        trigFall = core_q.trigSeen & ~core_q.trigSync[1];
        byteEv = core_q.togSync[1] ^ core_q.togSeen; // R15
        c = core_q.chan[1:0];
        chanOk = core_q.chan < 8'(stsp_pkg::NUM_CHAN);

        case (core_q.state)
            stsp_pkg::ST_IDLE: begin
                core_d.byteIdx = stsp_pkg::IDX_FUNC; // R24
                core_d.txByte = stsp_pkg::BYTE_RST;
                if (frameActive) begin // R7
                    core_d.state = stsp_pkg::ST_FRAME;
                end else if (trigFall) begin
                    // Loopback: the sensor takes the actuator value.
                    core_d.sensor = core_q.actuator; // R20
                    core_d.statusEv[0][stsp_pkg::ST_BIT_TRIG] = 1'b1;
                    core_d.statusEv[2][stsp_pkg::ST_BIT_TRIG] = 1'b1;
                    core_d.ackN = 1'b0; // R8
                    core_d.state = stsp_pkg::ST_TRIG;
                end
            end
            stsp_pkg::ST_TRIG: begin
                // Hold the acknowledge until the trigger is released.
                if (core_q.trigSync[1]) begin
                    core_d.ackN = 1'b1; // R9
                    core_d.state = stsp_pkg::ST_IDLE;
                end
            end
            stsp_pkg::ST_FRAME: begin
                if (!frameActive) begin
                    core_d.state = stsp_pkg::ST_IDLE; // R17
                end else if (byteEv) begin
                    case (core_q.byteIdx)
                        stsp_pkg::IDX_FUNC: begin
                            core_d.func = linkBus.rxByte;
                        end
                        stsp_pkg::IDX_CHAN: begin
                            core_d.chan = linkBus.rxByte;
                        end
                        default: begin
                            // Write frames fill words high byte first.
                            if (core_q.byteIdx == stsp_pkg::IDX_DATA) begin
                                if (core_q.func == stsp_pkg::FN_WRITE_DATA
                                    && core_q.chan == 8'h01) begin // R19
                                    core_d.actuator[15:8] = linkBus.rxByte;
                                end
                                if (core_q.func == stsp_pkg::FN_WRITE_MASK
                                    && chanOk) begin // R22
                                    core_d.mask[c][15:8] = linkBus.rxByte;
                                end
                                if (core_q.func == stsp_pkg::FN_WRITE_AUX_MASK
                                    && chanOk) begin // R22
                                    core_d.auxMask[c][15:8] = linkBus.rxByte;
                                end
                            end
                            if (core_q.byteIdx == stsp_pkg::IDX_DATA + 3'h1)
                            begin
                                if (core_q.func == stsp_pkg::FN_WRITE_DATA
                                    && core_q.chan == 8'h01) begin
                                    core_d.actuator[7:0] = linkBus.rxByte;
                                    core_d.statusEv[1][
                                        stsp_pkg::ST_BIT_WRITTEN] = 1'b1;
                                end
                                if (core_q.func == stsp_pkg::FN_WRITE_MASK
                                    && chanOk) begin
                                    core_d.mask[c][7:0] = linkBus.rxByte;
                                end
                                if (core_q.func == stsp_pkg::FN_WRITE_AUX_MASK
                                    && chanOk) begin
                                    core_d.auxMask[c][7:0] = linkBus.rxByte;
                                end
                                // Reading the low byte clears sticky bits.
                                if (core_q.func == stsp_pkg::FN_READ_STATUS
                                    && chanOk) begin
                                    core_d.statusEv[c] = stsp_pkg::WORD_RST;
                                end
                                if (core_q.func ==
                                    stsp_pkg::FN_READ_AUX_STATUS
                                    && chanOk) begin
                                    core_d.auxStat[c] = stsp_pkg::WORD_RST;
                                end
                            end
                        end
                    endcase
                    // Prepare the next outgoing byte before acknowledging.
                    core_d.txByte = readByte(core_d,
                                             core_q.byteIdx + 3'h1); // R2
                    if (core_q.byteIdx != stsp_pkg::IDX_MAX) begin
                        core_d.byteIdx = core_q.byteIdx + 3'h1;
                    end
                    core_d.ackN = 1'b0; // R4 R10
                    core_d.ackCnt = 8'(stsp_pkg::ACK_LOW_CYC - 1); // R18
                    core_d.state = stsp_pkg::ST_ACK;
                end
            end
            stsp_pkg::ST_ACK: begin
                // Byte acknowledge pulse of fixed low time.
                if (core_q.ackCnt == 8'h00) begin
                    core_d.ackN = 1'b1; // R15
                    core_d.state = frameActive ? stsp_pkg::ST_FRAME
                                               : stsp_pkg::ST_IDLE;
                end else begin
                    core_d.ackCnt = core_q.ackCnt - 8'h01;
                end
            end
            default: begin
                core_d.ackN = 1'b1;
                core_d.state = stsp_pkg::ST_IDLE;
            end
        endcase

        // Aux events are applied last, so a set beats a read clear.
        for (int i = 0; i < stsp_pkg::NUM_CHAN; i++) begin
            core_d.auxStat[i] = core_d.auxStat[i] | auxEvent[i];
        end

        // Warm-up timer gates the operational status bit.
        if (!core_q.ready) begin
            core_d.warmCnt = core_q.warmCnt + 20'h0_0001;
            if (core_q.warmCnt == 20'(WARMUP_CYCLES - 1)) begin
                core_d.ready = 1'b1; // R21
            end
        end

        // Service request through channel mask or aux mask.
        irq = 1'b0;
        for (int i = 0; i < stsp_pkg::NUM_CHAN; i++) begin
            if ((chanStatus(core_q, 2'(i)) & core_q.mask[i]) != 16'h0000
                || (core_q.auxStat[i] & core_q.auxMask[i]) != 16'h0000)
            begin
                irq = 1'b1; // R23
            end
        end
        core_d.svcN = ~irq; // R5
    end

    // Core state register.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_q <= '{frameSync: 2'h3, trigSync: 2'h3, trigSeen: 1'b1,
                        state: stsp_pkg::ST_IDLE, ackN: 1'b1, svcN: 1'b1,
                        default: '0};
        end else begin
            core_q <= core_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign linkBus.txByte = core_q.txByte;
    assign ackN = core_q.ackN;
    assign serviceReqN = core_q.svcN;
    assign presentN = 1'b0; // R25 R6
    assign actuatorValue = core_q.actuator;
    assign sensorValue = core_q.sensor;
    assign channelReady = core_q.ready;

endmodule : stsp_port

// ===== verif/stsp_port_assertions.sv
// Pin level checks for the transducer serial port.
`timescale 1ns/100ps
module stsp_port_assertions #(
    parameter int WARMUP_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic linkClk,
    input wire logic frameN,
    input wire logic trigN,
    input wire logic linkDataIn,
    input wire logic linkDataOut,
    input wire logic ackN,
    input wire logic serviceReqN,
    input wire logic presentN,
    input wire logic [2:0][15:0] auxEvent,
    input wire logic [15:0] actuatorValue,
    input wire logic [15:0] sensorValue,
    input wire logic channelReady
);
    // ****************************************************************
    // Helper counters and assertions
    // ****************************************************************
    logic [7:0] lowCnt_q;
    logic [31:0] upCnt_q;
    logic [15:0] holdCnt_q;
    // Longest time a trigger acknowledge may outlive its trigger.
    localparam int ACK_DROP_CYC = 1250;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Counts acknowledge low time, trigger release hold and uptime.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lowCnt_q <= 8'h00;
            upCnt_q <= 32'h0000_0000;
            holdCnt_q <= 16'h0000;
        end else begin
            lowCnt_q <= ackN ? 8'h00 : lowCnt_q + 8'h01;
            holdCnt_q <= (trigN && frameN && !ackN) ?
                holdCnt_q + 16'h0001 : 16'h0000;
            upCnt_q <= upCnt_q + {31'h0, ~upCnt_q[20]};
        end
    end
    a_present_low: assert property (presentN == 1'b0)
        else $error("presence line not low");
    a_byte_ack_width: assert property (
        $rose(ackN) && !frameN |-> lowCnt_q == stsp_pkg::ACK_LOW_CYC)
        else $error("byte acknowledge width wrong");
    a_trig_ack_fast: assert property (
        $fell(trigN) && frameN && ackN |-> ##[1:750] !ackN)
        else $error("trigger not acknowledged in time");
    a_trig_ack_drop: assert property (holdCnt_q < ACK_DROP_CYC)
        else $error("trigger acknowledge not removed");
    a_ack_cause: assert property (
        $fell(ackN) |-> !frameN || !trigN)
        else $error("acknowledge without frame or trigger");
    a_sensor_copy: assert property (
        $fell(ackN) && frameN |-> sensorValue == actuatorValue)
        else $error("sensor not loaded from actuator");
    a_sensor_hold: assert property (
        $changed(sensorValue) |-> $fell(ackN) && frameN)
        else $error("sensor changed without trigger");
    a_actuator_frame: assert property (
        $changed(actuatorValue) |-> !frameN)
        else $error("actuator changed outside a frame");
    a_ready_warm: assert property (
        upCnt_q > WARMUP_CYCLES + 2 |-> channelReady)
        else $error("channel not ready after warm-up");
    c_byte_ack: cover property ($rose(ackN) && !frameN);
    c_trig_ack: cover property ($fell(ackN) && frameN);
    c_service: cover property ($fell(serviceReqN));
endmodule : stsp_port_assertions

// ===== verif/stsp_ncap_model.sv
// Behavioural link controller at the far side of the port.
`timescale 1ns/100ps
module stsp_ncap_model (
    output logic linkClk,
    output logic frameN,
    output logic trigN,
    output logic linkDataIn,
    input wire logic linkDataOut,
    input wire logic ackN
);
    // Idle levels: clock parked low, frame and trigger released.
    initial begin
        linkClk = 1'b0;
        frameN = 1'b1;
        trigN = 1'b1;
        linkDataIn = 1'b0;
    end
    // Polls the acknowledge for a level, giving up after ns.
    task automatic wait_ack(input logic lvl, input int ns, output logic ok);
        for (int t = 0; t < ns && ackN !== lvl; t++)
            #1;
        ok = ackN === lvl;
    endtask : wait_ack
    // Sends n bytes MSB first, capturing the returned bits.
    task automatic frame(input logic [7:0] tx [6], input int n,
                         output logic [7:0] rx [6], output logic ok);
        logic hit;
        ok = 1'b1;
        frameN = 1'b0;
        #24;
        for (int b = 0; b < n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                linkDataIn = tx[b][i];
                #24;
                rx[b][i] = linkDataOut;
                linkClk = 1'b1;
                #24;
                linkClk = 1'b0;
            end
            wait_ack(1'b0, 100000, hit);
            ok &= hit;
            wait_ack(1'b1, 2000, hit);
            ok &= hit;
        end
        linkDataIn = ~linkDataIn;
        frameN = 1'b1;
        #50us;
    endtask : frame
    // Trigger handshake, then the settling time before any read.
    task automatic trigger(output logic ok);
        logic hit;
        trigN = 1'b0;
        wait_ack(1'b0, 6000, hit);
        ok = hit;
        #1us;
        trigN = 1'b1;
        wait_ack(1'b1, 10000, hit);
        ok &= hit;
        #160us;
    endtask : trigger
endmodule : stsp_ncap_model

// ===== verif/stsp_port_bench.sv
// Self-checking bench for the transducer serial port.
`timescale 1ns/100ps
`define CHECK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("unexpected at %0t: got %h expected %h", \
                     $time, got, exp); \
        end \
    end
module stsp_port_bench;
    localparam int WARM = 20;
    logic ref_clk, reset_n, linkClk, frameN, trigN, linkDataIn;
    logic linkDataOut, ackN, serviceReqN, presentN, channelReady, ok;
    logic [2:0][15:0] auxEvent;
    logic [15:0] actuatorValue, sensorValue;
    logic [7:0] rx [6];
    int failures = 0;
    int comparisons = 0;
    stsp_port #(.WARMUP_CYCLES(WARM)) stsp_port_i (.ref_clk, .reset_n,
        .linkClk, .frameN, .trigN, .linkDataIn, .linkDataOut, .ackN,
        .serviceReqN, .presentN, .auxEvent, .actuatorValue,
        .sensorValue, .channelReady);
    stsp_ncap_model stsp_ncap_model_i (.linkClk, .frameN, .trigN,
        .linkDataIn, .linkDataOut, .ackN);
    // Core clock at 125 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    // Runs one frame through the partner and checks its handshakes.
    task automatic run(input logic [7:0] tx [6], input int n);
        stsp_ncap_model_i.frame(tx, n, rx, ok);
        `CHECK(ok, 1'b1)
    endtask : run
    // Reset levels, then readiness after the shortened warm-up.
    task automatic test_reset;
        @(negedge ref_clk);
        `CHECK({ackN, serviceReqN, presentN}, 3'h6)
        `CHECK(channelReady, 1'b0)
        @(posedge ref_clk) reset_n <= 1'b1;
        repeat (WARM + 4) @(posedge ref_clk);
        #1;
        `CHECK(channelReady, 1'b1)
    endtask : test_reset
    // Writes the actuator; the sensor must not follow yet.
    task automatic test_write;
        run('{8'h00, 8'h01, 8'hA5, 8'hC3, 8'h00, 8'h00}, 4);
        `CHECK(actuatorValue, 16'hA5C3)
        `CHECK(sensorValue, 16'h0000)
    endtask : test_write
    // Trigger copies the actuator into the sensor.
    task automatic test_trigger;
        stsp_ncap_model_i.trigger(ok);
        `CHECK(ok, 1'b1)
        `CHECK(sensorValue, 16'hA5C3)
    endtask : test_trigger
    // Channel 0 read returns both channels, high byte first.
    task automatic test_read_all;
        logic [7:0] exp [6];
        exp = '{8'h00, 8'h00, 8'hA5, 8'hC3, 8'hA5, 8'hC3};
        run('{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 6);
        for (int i = 0; i < 6; i++) begin
            `CHECK(rx[i], exp[i])
        end
    endtask : test_read_all
    // Sensor status shows the trigger and operational bits.
    task automatic test_status;
        run('{8'h82, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, 4);
        `CHECK({rx[2], rx[3]}, 16'h0006)
    endtask : test_status
    // Aux events raise service through both mask paths.
    task automatic test_aux_irq;
        run('{8'h06, 8'h02, 8'h00, 8'h01, 8'h00, 8'h00}, 4);
        `CHECK(serviceReqN, 1'b1)
        @(posedge ref_clk) auxEvent[2] <= 16'h0001;
        @(posedge ref_clk) auxEvent[2] <= 16'h0000;
        repeat (3) @(posedge ref_clk);
        #1;
        `CHECK(serviceReqN, 1'b0)
        run('{8'h85, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, 4);
        `CHECK({rx[2], rx[3]}, 16'h0001)
        `CHECK(serviceReqN, 1'b1)
        run('{8'h04, 8'h02, 8'h00, 8'h08, 8'h00, 8'h00}, 4);
        `CHECK(serviceReqN, 1'b1)
        @(posedge ref_clk) auxEvent[2] <= 16'h0002;
        @(posedge ref_clk) auxEvent[2] <= 16'h0000;
        run('{8'h84, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, 4);
        `CHECK({rx[2], rx[3]}, 16'h0008)
        `CHECK(serviceReqN, 1'b0)
        run('{8'h86, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, 4);
        `CHECK({rx[2], rx[3]}, 16'h0001)
    endtask : test_aux_irq
    // Main sequence.
    initial begin
        reset_n = 1'b0;
        auxEvent = 48'h0000_0000_0000;
        repeat (3) @(posedge ref_clk);
        test_reset();
        test_write();
        test_trigger();
        test_read_all();
        test_status();
        test_aux_irq();
        final_report();
    end
    // Cuts a hung run short.
    initial begin
        #700us;
        failures++;
        final_report();
    end
endmodule : stsp_port_bench
bind stsp_port stsp_port_assertions #(.WARMUP_CYCLES(WARMUP_CYCLES))
    stsp_port_assertions_i (.ref_clk, .reset_n, .linkClk, .frameN,
    .trigN, .linkDataIn, .linkDataOut, .ackN, .serviceReqN, .presentN,
    .auxEvent, .actuatorValue, .sensorValue, .channelReady);
